// ### design/pllcg_pkg.sv
package pllcg_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CSR = 8'h00;
    localparam logic [7:0] OFS_MULT = 8'h10;
    localparam logic [7:0] OFS_DIV0 = 8'h14;
    localparam logic [7:0] OFS_DIV1 = 8'h18;
    localparam logic [7:0] OFS_DIV2 = 8'h1C;
    localparam logic [7:0] OFS_DIV3 = 8'h20;
    localparam logic [7:0] OFS_OSC = 8'h24;
    localparam logic [7:0] OFS_GCTL = 8'h28;
    localparam logic [7:0] OFS_DCFG = 8'h2C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CSR_PATH_BIT = 0;
    localparam int CSR_PDN_BIT = 1;
    localparam int CSR_RST_BIT = 3;
    localparam int CSR_STABLE_BIT = 6;
    localparam int DIV_EN_BIT = 15;
    localparam int RATIO_W = 5;
    localparam int GCTL_CLKOUT_TWO_ENABLE_BIT = 3;
    localparam int GCTL_MEMCLK_OUT_ENABLE_BIT = 5;
    localparam int DCFG_MEMCLK_SOURCE_SELECT_BIT = 4;

    // ------------------------------------------------------------
    // Reset values and multiplier range
    // ------------------------------------------------------------
    localparam logic [4:0] RST_DIV0 = 5'h00;
    localparam logic [4:0] RST_DIV1 = 5'h00;
    localparam logic [4:0] RST_DIV2 = 5'h01;
    localparam logic [4:0] RST_DIV3 = 5'h01;
    localparam logic [4:0] RST_OSC = 5'h07;
    localparam logic [4:0] RST_MULT = 5'h04;
    localparam logic [4:0] MULT_MIN = 5'h04;
    localparam logic [4:0] MULT_MAX = 5'h19;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = SETTLE_NS / CLK_PERIOD_NS;
    localparam int SETTLE_W = 8;
endpackage

// ### design/pllcg_divider.sv
`timescale 1ns/100ps
module pllcg_divider
    import pllcg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tick_in,
    input wire logic enable,
    input wire logic [RATIO_W-1:0] ratio,
    output logic tick_out
);
    // Ratio is only taken at the end of a period, so no short pulse
    logic [RATIO_W-1:0] cnt_q;
    logic [RATIO_W-1:0] lim_q;
    wire at_end = (cnt_q == lim_q);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 5'h00;
            lim_q <= 5'h00;
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in & at_end & enable;
            if (tick_in) begin
                cnt_q <= at_end ? 5'h00 : cnt_q + 5'h01;
                if (at_end) begin
                    lim_q <= ratio;
                end
            end
        end
    end

    period_hold_a: assert property ( // RULE22
        @(posedge clk) disable iff (sys_rst)
        tick_in && !at_end |=> $stable(lim_q))
        else $error("divider ratio changed mid period");
endmodule

// ### design/pllcg_top.sv
`timescale 1ns/100ps
// Operation
// RULE1 - Prescaler before PLL plus oscillator, core, bus and memory dividers.
// RULE2 - Software never writes zero to core or bus divider enable.
// RULE3 - Software holds PLL reset at least 125 ns before release.
// RULE4 - Software waits lock time (75 us typ, 187.5 us max) before PLL path.
// RULE5 - Clock out two runs only with bus enable and global bit 3.
// RULE6 - Clock out three is input clock divided /1 to /32, own enable.
// RULE7 - Memory clock out picks internal or external by config bit 4.
// RULE8 - Input clock goes undivided to audio ports as auxiliary clock.
// RULE9 - PLL path: prescale /1 to /32, then multiply x4 to x25.
// RULE10 - Path select zero uses input clock, one uses PLL output.
// RULE11 - Core, bus and memory clocks each have an own divider.
// RULE12 - Software keeps PLL reference 12-100 MHz and output 140-600 MHz.
// RULE13 - Software sets bus clock to exactly half the core clock.
// RULE14 - Bus system clock drives peripheral bus control.
// RULE15 - Bus system clock goes straight to clock out two.
// RULE16 - Memory clock is external input or memory divider output.
// RULE17 - Multiplier and all dividers reprogrammable at run time.
// RULE18 - Software enters bypass before changing PLL input or multiplier.
// RULE19 - Status register: path select, power down, PLL reset, stable.
// RULE20 - Divider registers: enable bit 15, ratio bits 4:0, zero is /1.
// RULE21 - Software orders core and bus divider writes, bus first to slow.
// RULE22 - Path and ratio changes give no truncated pulses.
// RULE23 - Stable flag rises only after a fixed settling count.
module pllcg_top
    import pllcg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pll_out_clock,
    input wire logic ext_mem_clock_in,
    output logic pll_ref_clock,
    output logic [4:0] pll_mult,
    output logic pll_reset_ctl,
    output logic pll_power_down,
    output logic core_sys_clk,
    output logic bus_sys_clk,
    output logic memif_sys_clk,
    output logic clock_out_two,
    output logic clock_out_three,
    output logic mem_clock_out,
    output logic audio_aux_clock
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic path_sel_q;
    logic [4:0] div_ratio_q [4];
    logic div_en_q [4];
    logic [4:0] osc_ratio_q;
    logic osc_en_q;
    logic clkout_two_enable_q;
    logic memclk_out_enable_q;
    logic memclk_source_select_q;
    logic [SETTLE_W-1:0] settle_q;
    logic stable_q;
    logic [31:0] rdata_d;

    function automatic logic [31:0] div_word(input logic en,
                                             input logic [4:0] r);
        div_word = {16'h0000, en, 10'h000, r};
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire req = avs_read | avs_write;
    wire acc = req & ~avs_waitrequest;
    wire wr = acc & avs_write;
    wire be_lo = avs_byteenable[0];
    wire be_hi = avs_byteenable[1];
    wire [7:0] div_ofs [4];
    assign div_ofs[0] = OFS_DIV0;
    assign div_ofs[1] = OFS_DIV1;
    assign div_ofs[2] = OFS_DIV2;
    assign div_ofs[3] = OFS_DIV3;
    wire wr_csr = wr && avs_address == OFS_CSR && be_lo;
    wire wr_mult = wr && avs_address == OFS_MULT && be_lo;
    wire wr_osc = wr && avs_address == OFS_OSC;
    wire wr_gctl = wr && avs_address == OFS_GCTL && be_lo;
    wire wr_dcfg = wr && avs_address == OFS_DCFG && be_lo;
    wire [31:0] csr_word = {25'h0000000, stable_q, 2'b00, pll_reset_ctl,
                            1'b0, pll_power_down, path_sel_q}; // RULE19

    always_comb begin
        case (avs_address)
            OFS_CSR: rdata_d = csr_word;
            OFS_MULT: rdata_d = {27'h0000000, pll_mult};
            OFS_DIV0: rdata_d = div_word(div_en_q[0], div_ratio_q[0]);
            OFS_DIV1: rdata_d = div_word(div_en_q[1], div_ratio_q[1]);
            OFS_DIV2: rdata_d = div_word(div_en_q[2], div_ratio_q[2]);
            OFS_DIV3: rdata_d = div_word(div_en_q[3], div_ratio_q[3]);
            OFS_OSC: rdata_d = div_word(osc_en_q, osc_ratio_q);
            OFS_GCTL: rdata_d = {26'h0000000, memclk_out_enable_q, 1'b0, clkout_two_enable_q, 3'h0};
            OFS_DCFG: rdata_d = {27'h0000000, memclk_source_select_q, 4'h0};
            default: rdata_d = 32'h00000000;
        endcase
    end

    // One wait cycle per access; data loaded while wait is high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rdata_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            path_sel_q <= 1'b0; // RULE19
            pll_power_down <= 1'b0;
            pll_reset_ctl <= 1'b1; // RULE19
            pll_mult <= RST_MULT;
            osc_ratio_q <= RST_OSC;
            osc_en_q <= 1'b1; // RULE6
            clkout_two_enable_q <= 1'b1; // RULE5
            memclk_out_enable_q <= 1'b1;
            memclk_source_select_q <= 1'b0;
        end else begin
            if (wr_csr) begin // RULE17
                path_sel_q <= avs_writedata[CSR_PATH_BIT];
                pll_power_down <= avs_writedata[CSR_PDN_BIT];
                pll_reset_ctl <= avs_writedata[CSR_RST_BIT];
            end
            if (wr_mult && avs_writedata[4:0] >= MULT_MIN &&
                avs_writedata[4:0] <= MULT_MAX) begin // RULE9
                pll_mult <= avs_writedata[4:0];
            end
            if (wr_osc && be_lo) begin
                osc_ratio_q <= avs_writedata[4:0];
            end
            if (wr_osc && be_hi) begin
                osc_en_q <= avs_writedata[DIV_EN_BIT];
            end
            if (wr_gctl) begin
                clkout_two_enable_q <= avs_writedata[GCTL_CLKOUT_TWO_ENABLE_BIT];
                memclk_out_enable_q <= avs_writedata[GCTL_MEMCLK_OUT_ENABLE_BIT];
            end
            if (wr_dcfg) begin
                memclk_source_select_q <= avs_writedata[DCFG_MEMCLK_SOURCE_SELECT_BIT];
            end
        end
    end

    localparam logic [4:0] DIV_RST [4] = '{RST_DIV0, RST_DIV1,
                                           RST_DIV2, RST_DIV3};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_divreg
            wire hit = wr && avs_address == div_ofs[gi];
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    div_ratio_q[gi] <= DIV_RST[gi];
                    div_en_q[gi] <= 1'b1; // RULE20
                end else begin
                    if (hit && be_lo) begin // RULE20
                        div_ratio_q[gi] <= avs_writedata[RATIO_W-1:0];
                    end
                    if (hit && be_hi) begin
                        div_en_q[gi] <= avs_writedata[DIV_EN_BIT];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Settling counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            settle_q <= 8'h00;
            stable_q <= 1'b0;
        end else if (!stable_q) begin // RULE23
            settle_q <= settle_q + 8'h01;
            stable_q <= (settle_q == SETTLE_W'(SETTLE_CYC - 1));
        end
    end

    // ------------------------------------------------------------
    // Clock tree
    // ------------------------------------------------------------
    logic ref_tick;
    logic core_tick;
    logic bus_tick;
    logic mem_tick;
    logic osc_tick;
    logic path_act_q;

    // Prescaler feeds the PLL reference; input clock is every cycle
    pllcg_divider u_pre ( // RULE1 RULE9
        .clk(clk), .sys_rst(sys_rst), .tick_in(1'b1),
        .enable(div_en_q[0]), .ratio(div_ratio_q[0]), .tick_out(ref_tick));

    // Path switch held until a core period boundary to avoid slivers
    wire hf_tick = path_act_q ? pll_out_clock : 1'b1; // RULE10
    wire sw_ok = core_tick | ~div_en_q[1];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            path_act_q <= 1'b0;
        end else if (sw_ok) begin // RULE22
            path_act_q <= path_sel_q;
        end
    end

    pllcg_divider u_core ( // RULE11
        .clk(clk), .sys_rst(sys_rst), .tick_in(hf_tick),
        .enable(div_en_q[1]), .ratio(div_ratio_q[1]), .tick_out(core_tick));
    pllcg_divider u_bus ( // RULE11 RULE14
        .clk(clk), .sys_rst(sys_rst), .tick_in(hf_tick),
        .enable(div_en_q[2]), .ratio(div_ratio_q[2]), .tick_out(bus_tick));
    pllcg_divider u_mem ( // RULE11 RULE16
        .clk(clk), .sys_rst(sys_rst), .tick_in(hf_tick),
        .enable(div_en_q[3]), .ratio(div_ratio_q[3]), .tick_out(mem_tick));
    pllcg_divider u_osc ( // RULE6
        .clk(clk), .sys_rst(sys_rst), .tick_in(1'b1),
        .enable(osc_en_q), .ratio(osc_ratio_q), .tick_out(osc_tick));

    wire two_d = bus_tick & div_en_q[2] & clkout_two_enable_q; // RULE5 RULE15
    wire mem_src = memclk_source_select_q ? ext_mem_clock_in : mem_tick; // RULE7 RULE16
    wire mem_d = mem_src & memclk_out_enable_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pll_ref_clock <= 1'b0;
            core_sys_clk <= 1'b0;
            bus_sys_clk <= 1'b0;
            memif_sys_clk <= 1'b0;
            clock_out_two <= 1'b0;
            clock_out_three <= 1'b0;
            mem_clock_out <= 1'b0;
            audio_aux_clock <= 1'b0;
        end else begin
            pll_ref_clock <= ref_tick;
            core_sys_clk <= core_tick;
            bus_sys_clk <= bus_tick; // RULE14
            memif_sys_clk <= mem_tick;
            clock_out_two <= two_d;
            clock_out_three <= osc_tick;
            mem_clock_out <= mem_d;
            audio_aux_clock <= 1'b1; // RULE8
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Bypass run length, so the core rate check skips ratio reloads
    logic [5:0] byp_run_q;
    wire byp_core = !path_act_q && div_en_q[1] && div_ratio_q[1] == 5'h00;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            byp_run_q <= 6'h00;
        end else if (!byp_core) begin
            byp_run_q <= 6'h00;
        end else if (byp_run_q != 6'h3F) begin
            byp_run_q <= byp_run_q + 6'h01;
        end
    end

    clkout_two_gate_a: assert property ( // RULE5
        @(posedge clk) disable iff (sys_rst)
        clock_out_two |-> bus_sys_clk && $past(clkout_two_enable_q))
        else $error("clock out two without its enables");
    clkout_two_follow_a: assert property ( // RULE15
        @(posedge clk) disable iff (sys_rst)
        bus_tick && clkout_two_enable_q |=> clock_out_two)
        else $error("clock out two missed a bus pulse");
    memclk_select_a: assert property ( // RULE7
        @(posedge clk) disable iff (sys_rst)
        memclk_source_select_q && memclk_out_enable_q && ext_mem_clock_in |=> mem_clock_out)
        else $error("memory clock did not follow external input");
    memclk_off_a: assert property ( // RULE7
        @(posedge clk) disable iff (sys_rst)
        !memclk_out_enable_q |=> !mem_clock_out)
        else $error("memory clock ran while disabled");
    aux_clock_run_a: assert property ( // RULE8
        @(posedge clk) disable iff (sys_rst)
        !$past(sys_rst) |-> audio_aux_clock)
        else $error("auxiliary clock stopped");
    stable_wait_a: assert property ( // RULE23
        @(posedge clk) disable iff (sys_rst)
        $rose(stable_q) |-> $past(settle_q) == SETTLE_W'(SETTLE_CYC - 1))
        else $error("stable flag rose early");
    path_bypass_a: assert property ( // RULE10
        @(posedge clk) disable iff (sys_rst)
        byp_run_q == 6'h3F |-> core_sys_clk)
        else $error("bypass core clock not at input rate");
    path_switch_a: assert property ( // RULE22
        @(posedge clk) disable iff (sys_rst)
        path_act_q != $past(path_act_q) |-> $past(sw_ok))
        else $error("path switched off a period boundary");
    bus_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");
    csr_reset_a: assert property ( // RULE19
        @(posedge clk)
        $fell(sys_rst) |-> pll_reset_ctl && !path_sel_q)
        else $error("status register reset value wrong");
endmodule

// ### sim/pllcg_far_model.sv
`timescale 1ns/100ps
module pllcg_far_model #(
    parameter int LOCK_CYC = 18750
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pll_reset_ctl,
    input wire logic pll_power_down,
    input wire logic [4:0] pll_mult,
    output logic pll_out_clock,
    output logic ext_mem_clock_in
);
    int lock_q;
    logic [1:0] ph_q;
    logic [4:0] mult_q;
    wire held = pll_reset_ctl | pll_power_down;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_q <= 0;
            ph_q <= 2'h0;
            mult_q <= 5'h00;
            pll_out_clock <= 1'b0;
            ext_mem_clock_in <= 1'b0;
        end else begin
            ph_q <= ph_q + 2'h1;
            mult_q <= pll_mult;
            ext_mem_clock_in <= ph_q[1];
            // Relock after reset, power down or a new multiplier
            if (held || pll_mult != mult_q) begin
                lock_q <= 0;
            end else if (lock_q < LOCK_CYC) begin
                lock_q <= lock_q + 1;
            end
            if (held) begin
                pll_out_clock <= 1'b0;
            end else if (lock_q == LOCK_CYC) begin
                pll_out_clock <= ~pll_out_clock;
            end else begin
                // Unlocked: one pulse every fourth cycle
                pll_out_clock <= (ph_q == 2'h0);
            end
        end
    end
endmodule

// ### sim/pllcg_top_bench.sv
`timescale 1ns/100ps
module pllcg_top_bench;
    import pllcg_pkg::*;
    localparam int LOCK_CYC = 18750;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [4:0] pll_mult;
    logic pll_out_clock, ext_mem_clock_in, pll_ref_clock, pll_reset_ctl;
    logic pll_power_down, core_sys_clk, bus_sys_clk, memif_sys_clk;
    logic clock_out_two, clock_out_three, mem_clock_out, audio_aux_clock;
    int fail_count = 0;
    int checks = 0;
    int cnt [8];
    logic [31:0] rd;
    wire [7:0] outs = {audio_aux_clock, mem_clock_out, clock_out_three,
        clock_out_two, memif_sys_clk, bus_sys_clk, core_sys_clk, pll_ref_clock};

    pllcg_top u_pllcg_top (.clk(clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pll_out_clock(pll_out_clock),
        .ext_mem_clock_in(ext_mem_clock_in), .pll_ref_clock(pll_ref_clock),
        .pll_mult(pll_mult), .pll_reset_ctl(pll_reset_ctl),
        .pll_power_down(pll_power_down), .core_sys_clk(core_sys_clk),
        .bus_sys_clk(bus_sys_clk), .memif_sys_clk(memif_sys_clk),
        .clock_out_two(clock_out_two), .clock_out_three(clock_out_three),
        .mem_clock_out(mem_clock_out), .audio_aux_clock(audio_aux_clock));

    pllcg_far_model #(.LOCK_CYC(LOCK_CYC)) u_pllcg_far_model (.clk(clk),
        .sys_rst(sys_rst), .pll_reset_ctl(pll_reset_ctl),
        .pll_power_down(pll_power_down), .pll_mult(pll_mult),
        .pll_out_clock(pll_out_clock), .ext_mem_clock_in(ext_mem_clock_in));

    initial forever #5 clk = ~clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic bus_xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus_xfer(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Order: ref, core, bus, memif, out two, out three, mem out, aux
    task automatic cnt_chk(input int e [8]);
        cnt = '{default: 0};
        repeat (96) begin
            @(negedge clk);
            foreach (cnt[i]) cnt[i] += int'(outs[i]);
        end
        foreach (cnt[i]) check(cnt[i], e[i]);
    endtask

    task automatic give_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_reset();
        logic [7:0] a [9] = '{OFS_CSR, OFS_MULT, OFS_DIV0, OFS_DIV1,
            OFS_DIV2, OFS_DIV3, OFS_OSC, OFS_GCTL, OFS_DCFG};
        logic [31:0] v [9] = '{32'h08, 32'h04, 32'h8000, 32'h8000,
            32'h8001, 32'h8001, 32'h8007, 32'h28, 32'h00};
        foreach (a[i]) rd_chk(a[i], v[i]);
        check(32'(pll_reset_ctl), 32'h1);
        bus_xfer(1'b1, 8'h04, 32'hFFFFFFFF);
        rd_chk(8'h04, 32'h0);
        avs_byteenable <= 4'h2;
        bus_xfer(1'b1, OFS_DIV3, 32'h0000);
        avs_byteenable <= 4'h1;
        bus_xfer(1'b1, OFS_DIV3, 32'h8000);
        avs_byteenable <= 4'hF;
        rd_chk(OFS_DIV3, 32'h0000);
        bus_xfer(1'b1, OFS_DIV3, 32'h8001);
        bus_xfer(1'b1, OFS_CSR, 32'h48);
        rd_chk(OFS_CSR, 32'h08);
        $display("test reset done");
    endtask

    task automatic s_stable();
        idle(200);
        rd_chk(OFS_CSR, 32'h48);
        $display("test stable done");
    endtask

    task automatic s_gates();
        cnt_chk('{96, 96, 48, 48, 48, 12, 48, 96});
        bus_xfer(1'b1, OFS_OSC, 32'h8000);
        idle(40);
        cnt_chk('{96, 96, 48, 48, 48, 96, 48, 96});
        bus_xfer(1'b1, OFS_OSC, 32'h0000);
        bus_xfer(1'b1, OFS_GCTL, 32'h08);
        idle(40);
        cnt_chk('{96, 96, 48, 48, 48, 0, 0, 96});
        bus_xfer(1'b1, OFS_GCTL, 32'h20);
        bus_xfer(1'b1, OFS_DCFG, 32'h10);
        bus_xfer(1'b1, OFS_DIV3, 32'h0001);
        idle(40);
        cnt_chk('{96, 96, 48, 0, 0, 0, 48, 96});
        bus_xfer(1'b1, OFS_GCTL, 32'h28);
        bus_xfer(1'b1, OFS_DCFG, 32'h00);
        bus_xfer(1'b1, OFS_DIV3, 32'h8001);
        bus_xfer(1'b1, OFS_OSC, 32'h8007);
        $display("test gates done");
    endtask

    task automatic s_ratios();
        bus_xfer(1'b1, OFS_DIV2, 32'h8003);
        bus_xfer(1'b1, OFS_DIV1, 32'h8001);
        idle(40);
        cnt_chk('{96, 48, 24, 48, 24, 12, 48, 96});
        bus_xfer(1'b1, OFS_DIV1, 32'h8000);
        bus_xfer(1'b1, OFS_DIV2, 32'h8001);
        bus_xfer(1'b1, OFS_MULT, 32'h03);
        rd_chk(OFS_MULT, 32'h04);
        bus_xfer(1'b1, OFS_MULT, 32'h1A);
        rd_chk(OFS_MULT, 32'h04);
        bus_xfer(1'b1, OFS_MULT, 32'h19);
        rd_chk(OFS_MULT, 32'h19);
        check(32'(pll_mult), 32'h19);
        $display("test ratios done");
    endtask

    task automatic s_pll();
        bus_xfer(1'b1, OFS_CSR, 32'h0A);
        idle(2);
        check(32'({pll_power_down, pll_reset_ctl}), 32'h3);
        bus_xfer(1'b1, OFS_MULT, 32'h05);
        bus_xfer(1'b1, OFS_DIV0, 32'h8001);
        bus_xfer(1'b1, OFS_CSR, 32'h08);
        idle(13);
        bus_xfer(1'b1, OFS_CSR, 32'h00);
        idle(2);
        check(32'({pll_power_down, pll_reset_ctl}), 32'h0);
        idle(LOCK_CYC + 10);
        bus_xfer(1'b1, OFS_CSR, 32'h01);
        idle(60);
        rd_chk(OFS_CSR, 32'h41);
        cnt_chk('{48, 48, 24, 24, 24, 12, 24, 96});
        $display("test pll path done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        s_reset();
        s_stable();
        s_gates();
        s_ratios();
        s_pll();
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
endmodule
